// File: backplane_pmd_tx_control_tb.sv
`timescale 1ns/1ps
module backplane_pmd_tx_control_tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tf = 1'b0, rf = 1'b0, xf = 1'b0;
    logic quiet = 1'b0, rx_req, ten, full, rxlpi, irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic [1:0] req = 2'h2;
    logic [15:0] txd = 16'hA5C3, lrx, ltxd, rxd;
    int error_cnt = 0, check_count = 0, cyc = 0;
    bptx_link_model peer (.i_mclk(clk), .i_quiet(quiet), .o_word(lrx), .o_rx_req(rx_req));
    bptx_ctrl #(.DATA_CYC(4)) dut (.i_mclk(clk), .i_srst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_lpi_request(req), .i_rx_lpi_request(rx_req),
        .i_tx_data(txd), .i_line_rx_data(lrx), .i_tx_fault_det(tf), .i_rx_fault_det(rf),
        .i_impl_fault_det(xf), .o_line_tx_data(ltxd), .o_line_tx_en(ten), .o_line_tx_full(full),
        .o_rx_data(rxd), .o_rx_lpi(rxlpi), .o_irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle; read data is taken in the cycle after the strobe
    task automatic bus(input logic [7:0] a, input logic [31:0] v, input logic w);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 r = rdata;
    endtask
    // Fault inputs and rx sleep change together on an edge
    task automatic setin(input logic t, input logic x, input logic m, input logic q);
        @(posedge clk);
        {tf, rf, xf, quiet} <= {t, x, m, q};
        repeat (3) @(posedge clk);
    endtask
    task automatic t_modes();
        logic [1:0] m[3] = '{2'h0, 2'h1, 2'h2};
        logic [15:0] e[3] = '{16'h0, 16'hFF00, 16'hA5C3};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            req <= m[k];
            repeat (2) @(posedge clk);
            #1 chk({k != 0, e[k]}, {ten, ltxd});
        end
        chk(full, 1'b0);
        repeat (6) @(posedge clk);
        #1 chk(full, 1'b1);
        // Spare code 2'b11 must behave as DATA
        @(posedge clk);
        req <= 2'h3;
        repeat (2) @(posedge clk);
        #1 chk({ten, ltxd}, {1'b1, txd});
        @(posedge clk);
        req <= 2'h2;
        $display("modes done");
    endtask
    task automatic t_path();
        bus(8'h00, 32'hB, 1'b1);
        #30 chk({ten, ltxd}, {1'b0, 16'h0});
        chk(rxd, txd);
        bus(8'h00, 32'h8, 1'b1);
        #30 chk({ten, rxd}, {1'b1, 16'(lrx - 16'h3C5B)});
        $display("path done");
    endtask
    // Expected status words: bit0 off, 1 fault, 2 tx fault, 3 rx fault, 4 tx enabled
    task automatic t_fault();
        setin(1'b1, 1'b0, 1'b0, 1'b0);
        bus(8'h04, 32'h0, 1'b0);
        chk(r & 32'h1F, 32'h7);
        setin(1'b0, 1'b1, 1'b0, 1'b0);
        bus(8'h00, 32'h8, 1'b1);
        bus(8'h04, 32'h0, 1'b0);
        chk(r & 32'h1F, 32'h1A);
        setin(1'b0, 1'b0, 1'b1, 1'b0);
        bus(8'h00, 32'hC, 1'b1);
        bus(8'h04, 32'h0, 1'b0);
        chk(r & 32'h1F, 32'h2);
        setin(1'b0, 1'b0, 1'b0, 1'b0);
        bus(8'h00, 32'h1, 1'b1);
        bus(8'h04, 32'h0, 1'b0);
        chk(r & 32'h1F, 32'h1);
        bus(8'h00, 32'h8, 1'b1);
        $display("faults done");
    endtask
    task automatic t_irq();
        bus(8'h08, 32'h0, 1'b0);
        chk(r & 32'h17, 32'h17);
        bus(8'h10, 32'h8, 1'b1);
        bus(8'h0C, 32'h1F, 1'b1);
        setin(1'b0, 1'b0, 1'b0, 1'b1);
        chk({rxlpi, irq, ten}, 3'h7);
        bus(8'h10, 32'h0, 1'b1);
        bus(8'h40, 32'h0, 1'b0);
        chk(r, 32'h0);
        chk(irq, 1'b0);
        $display("irq done");
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Runs take about 80 cycles, so 3000 means a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(8'h00, 32'h0, 1'b0);
        chk(r, 32'h8);
        bus(8'h04, 32'h0, 1'b0);
        chk(r, 32'h30);
        t_modes();
        t_path();
        t_fault();
        t_irq();
        print_verdict();
    end
endmodule
bind bptx_ctrl bptx_checker u_chk (.i_mclk, .i_srst, .i_rd, .o_rdata, .i_tx_lpi_request,
    .i_rx_lpi_request, .i_tx_data, .i_line_rx_data, .o_line_tx_data, .o_line_tx_en,
    .o_line_tx_full, .o_rx_data, .o_rx_lpi);

// File: bptx_checker.sv
`timescale 1ns/1ps
module bptx_checker (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] i_tx_lpi_request,
    input wire logic i_rx_lpi_request,
    input wire logic [15:0] i_tx_data,
    input wire logic [15:0] i_line_rx_data,
    input wire logic [15:0] o_line_tx_data,
    input wire logic o_line_tx_en,
    input wire logic o_line_tx_full,
    input wire logic [15:0] o_rx_data,
    input wire logic o_rx_lpi
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Outputs trail the request by one register
    a_quiet_off: assert property (i_tx_lpi_request == 2'h0 |=> !o_line_tx_en)
        else $error("tx on in quiet");
    a_alert_pat: assert property (o_line_tx_en && $past(i_tx_lpi_request) == 2'h1
        |-> o_line_tx_data == 16'hFF00) else $error("bad alert word");
    a_data_pass: assert property (o_line_tx_en && $past(i_tx_lpi_request) == 2'h2
        |-> o_line_tx_data == $past(i_tx_data)) else $error("bad data word");
    a_off_flat: assert property (!o_line_tx_en |-> o_line_tx_data == 16'h0)
        else $error("off line not flat");
    a_rx_follow: assert property (!$past(i_srst) |-> o_rx_lpi == !$past(i_rx_lpi_request))
        else $error("rx lpi wrong");
    a_rx_path: assert property (!$past(i_srst) |-> o_rx_data == $past(i_tx_data)
        || o_rx_data == $past(i_line_rx_data)) else $error("rx word from nowhere");
    // Holds for the bench's short settle count only
    a_full_settle: assert property ((o_line_tx_en && i_tx_lpi_request == 2'h2)[*8]
        |-> o_line_tx_full) else $error("full late");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("rdata not idle");
endmodule

// File: bptx_ctrl.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Transmit-off function is always built since low-power idle is supported.
// - Global transmit-off forces constant output level with no transitions.
// - Aggregate fault may switch the transmitter off, when enabled.
// - Transmit-off never changes loopback; looped data still reaches receive path.
// - On QUIET request, output goes idle within 500 ns and stays idle.
// - On ALERT request, transmitter restarts within 500 ns at full swing.
// - On DATA request, output is fully compliant within 5 us.
// - Loopback routes transmit data into receive path, ignoring link input.
// - Aggregate fault is OR of receive, transmit and other faults.
// - Transmit-off alone is never reported as a transmit fault.
// - A transmit fault also asserts the global transmit-off control.
// - Receive and transmit fault detectors drive their own status bits.
// - Transmitter signals sleep, refresh and wake to partner per mode requests.
// - Receive low-power state follows partner, independent of transmit state.
// - During ALERT a repeating 16-bit pattern 0xFF00 is sent.
module bptx_ctrl #(
    parameter int DATA_W = 16,
    parameter int DATA_CYC = bptx_pkg::BPTX_DATA_CYC
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [1:0] i_tx_lpi_request,
    input wire logic i_rx_lpi_request,
    input wire logic [DATA_W-1:0] i_tx_data,
    input wire logic [DATA_W-1:0] i_line_rx_data,
    input wire logic i_tx_fault_det,
    input wire logic i_rx_fault_det,
    input wire logic i_impl_fault_det,
    output logic [DATA_W-1:0] o_line_tx_data,
    output logic o_line_tx_en,
    output logic o_line_tx_full,
    output logic [DATA_W-1:0] o_rx_data,
    output logic o_rx_lpi,
    output logic o_irq
);
    localparam int CW = $clog2(DATA_CYC + 1);

    logic [3:0] ctrl_q;
    logic tx_fault_flag_q;
    logic rx_fault_flag_q;
    logic sublayer_fault_flag_q;
    logic [1:0] mode_q;
    logic [CW-1:0] settle_q;
    logic [4:0] irq_st_q;
    logic [4:0] irq_en_q;
    logic [DATA_W-1:0] tx_q;
    logic tx_en_q;
    logic full_q;
    logic [DATA_W-1:0] rx_q;
    logic rx_lpi_q;
    logic [31:0] rdata_q;
    logic irq_q;

    // Decoded controls and conditions
    wire wr_ctrl = i_wr && (i_addr == bptx_pkg::BPTX_OFF_CTRL);
    wire wr_clr = i_wr && (i_addr == bptx_pkg::BPTX_OFF_IRQ_CLR);
    wire wr_en = i_wr && (i_addr == bptx_pkg::BPTX_OFF_IRQ_EN);
    wire loop_sel = ctrl_q[bptx_pkg::BPTX_CTRL_LOOP];
    // Fault feeds transmit-off only when software allows it, since turning off is optional
    wire flt_off = ctrl_q[bptx_pkg::BPTX_CTRL_FLTOFF] && sublayer_fault_flag_q;
    // Transmit fault forces the control bit; the control bit never feeds the fault
    wire global_tx_off_ctl = ctrl_q[bptx_pkg::BPTX_CTRL_TXOFF];
    wire req_quiet = (i_tx_lpi_request == bptx_pkg::BPTX_TX_QUIET);
    wire req_alert = (i_tx_lpi_request == bptx_pkg::BPTX_TX_ALERT);
    // Unused code 2'b11 is treated as DATA
    wire req_data = !req_quiet && !req_alert;
    wire tx_on_d = !global_tx_off_ctl && !flt_off && !req_quiet;
    wire mode_chg = (i_tx_lpi_request != mode_q);
    wire [4:0] ev = {mode_chg && req_data,
        (i_rx_lpi_request == bptx_pkg::BPTX_RX_QUIET) && !rx_lpi_q,
        mode_chg && req_alert,
        mode_chg && req_quiet,
        (i_tx_fault_det || i_rx_fault_det || i_impl_fault_det) && !sublayer_fault_flag_q};
    wire [31:0] stat_w = {25'h0000000, rx_lpi_q, full_q, tx_en_q, rx_fault_flag_q,
        tx_fault_flag_q, sublayer_fault_flag_q, global_tx_off_ctl};
    wire [31:0] rd_mux = (i_addr == bptx_pkg::BPTX_OFF_CTRL) ? {28'h0000000, ctrl_q} :
        (i_addr == bptx_pkg::BPTX_OFF_STAT) ? stat_w :
        (i_addr == bptx_pkg::BPTX_OFF_IRQ_STAT) ? {27'h0000000, irq_st_q} :
        (i_addr == bptx_pkg::BPTX_OFF_IRQ_EN) ? {27'h0000000, irq_en_q} : 32'h00000000;

    // Control register; a transmit fault sets transmit-off and wins over a write
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl_q <= bptx_pkg::BPTX_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_wdata[3:0];
            end
            if (i_tx_fault_det && ctrl_q[bptx_pkg::BPTX_CTRL_AUTOOFF]) begin
                ctrl_q[bptx_pkg::BPTX_CTRL_TXOFF] <= 1'b1;
            end
        end
    end

    // Fault flags follow the detectors; aggregate is their OR
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            tx_fault_flag_q <= 1'b0;
            rx_fault_flag_q <= 1'b0;
            sublayer_fault_flag_q <= 1'b0;
        end else begin
            tx_fault_flag_q <= i_tx_fault_det;
            rx_fault_flag_q <= i_rx_fault_det;
            sublayer_fault_flag_q <= i_tx_fault_det || i_rx_fault_det || i_impl_fault_det;
        end
    end

    // Mode tracking and DATA settle counter for the full-compliance indication
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            mode_q <= bptx_pkg::BPTX_TX_DATA;
            settle_q <= '0;
            full_q <= 1'b1;
        end else begin
            mode_q <= i_tx_lpi_request;
            if (!req_data || !tx_on_d) begin
                settle_q <= '0;
                full_q <= 1'b0;
            end else if (settle_q != CW'(DATA_CYC - 1)) begin
                settle_q <= settle_q + CW'(1);
                full_q <= (mode_q != bptx_pkg::BPTX_TX_DATA) ? 1'b0 : full_q;
            end else begin
                full_q <= 1'b1;
            end
        end
    end

    // Line output: one cycle after request, well inside 500 ns; idle holds a constant zero
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            tx_q <= '0;
            tx_en_q <= 1'b0;
        end else begin
            tx_en_q <= tx_on_d;
            if (!tx_on_d) begin
                tx_q <= '0;
            end else if (req_alert) begin
                tx_q <= DATA_W'(bptx_pkg::BPTX_ALERT_PAT);
            end else begin
                tx_q <= i_tx_data;
            end
        end
    end

    // Receive path: loopback takes the transmit data regardless of transmit-off
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rx_q <= '0;
            rx_lpi_q <= 1'b0;
        end else begin
            rx_q <= loop_sel ? i_tx_data : i_line_rx_data;
            rx_lpi_q <= (i_rx_lpi_request == bptx_pkg::BPTX_RX_QUIET);
        end
    end

    // Interrupts: a new event wins over a clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~(wr_clr ? i_wdata[4:0] : 5'h00)) | ev;
            if (wr_en) begin
                irq_en_q <= i_wdata[4:0];
            end
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= i_rd ? rd_mux : 32'h00000000;
        end
    end

    assign o_rdata = rdata_q;
    assign o_line_tx_data = tx_q;
    assign o_line_tx_en = tx_en_q;
    assign o_line_tx_full = full_q;
    assign o_rx_data = rx_q;
    assign o_rx_lpi = rx_lpi_q;
    assign o_irq = irq_q;
endmodule

// File: bptx_link_model.sv
`timescale 1ns/1ps
// Far-side partner: drives our receive line and our rx low-power request
module bptx_link_model (
    input wire logic i_mclk,
    input wire logic i_quiet,
    output logic [15:0] o_word,
    output logic o_rx_req
);
    logic [15:0] cnt_q = 16'h1234;
    // Line word moves every cycle, so a stale copy never matches by luck
    always_ff @(posedge i_mclk) begin
        cnt_q <= cnt_q + 16'h3C5B;
    end
    assign o_word = cnt_q;
    // Partner only ever asks for QUIET or DATA
    assign o_rx_req = i_quiet ? bptx_pkg::BPTX_RX_QUIET : bptx_pkg::BPTX_RX_DATA;
endmodule

// File: bptx_pkg.sv
package bptx_pkg;
    // Transmit power-state request codes
    typedef enum logic [1:0] {
        BPTX_TX_QUIET = 2'b00,
        BPTX_TX_ALERT = 2'b01,
        BPTX_TX_DATA = 2'b10
    } bptx_txmode_t;

    // Receive power-state request codes
    localparam logic BPTX_RX_QUIET = 1'b0;
    localparam logic BPTX_RX_DATA = 1'b1;

    // Register offsets (byte addresses)
    localparam logic [7:0] BPTX_OFF_CTRL = 8'h00;
    localparam logic [7:0] BPTX_OFF_STAT = 8'h04;
    localparam logic [7:0] BPTX_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] BPTX_OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] BPTX_OFF_IRQ_EN = 8'h10;

    // Control register fields
    localparam int BPTX_CTRL_TXOFF = 0;
    localparam int BPTX_CTRL_LOOP = 1;
    localparam int BPTX_CTRL_FLTOFF = 2;
    localparam int BPTX_CTRL_AUTOOFF = 3;
    localparam logic [3:0] BPTX_CTRL_RST = 4'h8;

    // Status register fields
    localparam int BPTX_ST_TXOFF = 0;
    localparam int BPTX_ST_SUBFLT = 1;
    localparam int BPTX_ST_TXFLT = 2;
    localparam int BPTX_ST_RXFLT = 3;
    localparam int BPTX_ST_TXEN = 4;
    localparam int BPTX_ST_FULL = 5;
    localparam int BPTX_ST_RXLPI = 6;

    // Interrupt event bits
    localparam int BPTX_EV_SUBFLT = 0;
    localparam int BPTX_EV_QUIET = 1;
    localparam int BPTX_EV_WAKE = 2;
    localparam int BPTX_EV_RXQ = 3;
    localparam int BPTX_EV_W = 4;

    // Alert pattern and timing
    localparam logic [15:0] BPTX_ALERT_PAT = 16'hFF00;
    localparam int BPTX_CLK_MHZ = 40;
    localparam int BPTX_QUIET_NS = 500;
    localparam int BPTX_ALERT_NS = 500;
    localparam int BPTX_DATA_US = 5;
    localparam int BPTX_QUIET_CYC = (BPTX_QUIET_NS * BPTX_CLK_MHZ) / 1000;
    localparam int BPTX_ALERT_CYC = (BPTX_ALERT_NS * BPTX_CLK_MHZ) / 1000;
    localparam int BPTX_DATA_CYC = BPTX_DATA_US * BPTX_CLK_MHZ;
endpackage
